// ==== rtl/ftcb_pkg.sv ====
// Constants, types and address decode for the channel B upper tap coefficient bank.
// Assumes a byte-wide register port in which one address holds one byte.
package ftcb_pkg;

   localparam int unsigned ADDR_W = 15;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CENTER_W = 18;
   localparam int unsigned OUTER_W = 12;
   localparam int unsigned NUM_SLOTS = 11;
   localparam int unsigned SLOT_W = 4;
   localparam int unsigned IMAGE_W = NUM_SLOTS * DATA_W;

   // Register base addresses, low byte first
   localparam logic [ADDR_W-1:0] TAP4_ADDR = 15'h0450;
   localparam logic [ADDR_W-1:0] TAP5_ADDR = 15'h0453;
   localparam logic [ADDR_W-1:0] TAP6_ADDR = 15'h0455;
   localparam logic [ADDR_W-1:0] TAP7_ADDR = 15'h0457;
   localparam logic [ADDR_W-1:0] TAP8_ADDR = 15'h0459;
   localparam logic [ADDR_W-1:0] BANK_LAST_ADDR = 15'h045a;

   // Byte slots of the stored image
   localparam logic [SLOT_W-1:0] TAP4_TOP_SLOT = 4'h2;
   localparam logic [SLOT_W-1:0] TAP8_MSB_SLOT = 4'ha;

   // Coefficient field positions within the flat image
   localparam int unsigned TAP4_LSB = 0;
   localparam int unsigned TAP5_LSB = 24;
   localparam int unsigned TAP6_LSB = 40;
   localparam int unsigned TAP7_LSB = 56;
   localparam int unsigned TAP8_LSB = 72;

   localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] TAP8_MSB_MASK = 8'hf7;
   localparam logic [DATA_W-1:0] READ_NONE = 8'h00;

   typedef logic signed [CENTER_W-1:0] ftcb_center_t;
   typedef logic signed [OUTER_W-1:0] ftcb_outer_t;
   typedef enum logic {FTCB_SINGLE, FTCB_DUAL} ftcb_mode_t;

   // Returns {hit, slot} for a register address
   function automatic logic [SLOT_W:0] ftcb_decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] diff;
      diff = addr - TAP4_ADDR;
      if (addr >= TAP4_ADDR && addr <= BANK_LAST_ADDR) begin
         ftcb_decode = {1'b1, diff[SLOT_W-1:0]};
      end else begin
         ftcb_decode = {1'b0, {SLOT_W{1'b0}}};
      end
   endfunction

endpackage

// ==== rtl/ftcb_store_if.sv ====
// Connection between the register decode and the coefficient byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ftcb_store_if;
   import ftcb_pkg::*;
   logic wr;
   logic rd;
   logic hit;
   logic [SLOT_W-1:0] slot;
   logic [DATA_W-1:0] wdata;
   logic [IMAGE_W-1:0] image;
   logic [DATA_W-1:0] rdata;
   modport ctrl (output wr, rd, hit, slot, wdata, input image, rdata);
   modport store (input wr, rd, hit, slot, wdata, output image, rdata);
endinterface

// ==== rtl/ftcb_store.sv ====
// Byte store for the five coefficient registers with registered read data.
// Assumes the decode has already checked the address range.
`timescale 1ns/1ps
module ftcb_store
   import ftcb_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   ftcb_store_if.store bus_if
);

   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] sel_byte;

   genvar k;
   generate
      for (k = 0; k < NUM_SLOTS; k++) begin : g_byte
         logic [DATA_W-1:0] q_r;
         logic [DATA_W-1:0] q_nxt;
         always_comb begin
            q_nxt = q_r;
            if (bus_if.wr && bus_if.slot == SLOT_W'(k)) begin
               q_nxt = bus_if.wdata;
            end
         end
         always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
               q_r <= BYTE_RESET;
            end else begin
               q_r <= q_nxt;
            end
         end
         assign bus_if.image[k*DATA_W +: DATA_W] = q_r;
      end
   endgenerate

   always_comb begin
      sel_byte = bus_if.image[bus_if.slot*DATA_W +: DATA_W];
      rdata_nxt = rdata_r;
      if (bus_if.rd) begin
         if (!bus_if.hit) begin
            rdata_nxt = READ_NONE;
         end else if (bus_if.slot == TAP8_MSB_SLOT) begin
            // Known readback flaw kept so software sees what silicon returns
            rdata_nxt = sel_byte & TAP8_MSB_MASK;
         end else begin
            rdata_nxt = sel_byte;
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_r <= READ_NONE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign bus_if.rdata = rdata_r;

endmodule

// ==== rtl/ftcb_bank.sv ====
// Channel B coefficient bank for taps five to nine of the equaliser filter.
// Assumes a byte-wide register port synchronous to clock_in and a mode level
// from the channel configuration; channel A coefficients arrive ready to use.
`timescale 1ns/1ps
module ftcb_bank
   import ftcb_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic dual_mode_in,
   input wire ftcb_center_t chan_a_tap4_in,
   input wire ftcb_outer_t chan_a_tap5_in,
   input wire ftcb_outer_t chan_a_tap6_in,
   input wire ftcb_outer_t chan_a_tap7_in,
   input wire ftcb_outer_t chan_a_tap8_in,
   output ftcb_center_t tap4_coeff_out,
   output ftcb_outer_t tap5_coeff_out,
   output ftcb_outer_t tap6_coeff_out,
   output ftcb_outer_t tap7_coeff_out,
   output ftcb_outer_t tap8_coeff_out,
   output logic tap_src_b_out
);

   ftcb_store_if st_if ();

   logic [SLOT_W:0] dec;
   logic rvalid_r;
   logic rvalid_nxt;
   ftcb_mode_t mode;
   ftcb_center_t tap4_r;
   ftcb_center_t tap4_nxt;
   ftcb_outer_t tap5_r;
   ftcb_outer_t tap5_nxt;
   ftcb_outer_t tap6_r;
   ftcb_outer_t tap6_nxt;
   ftcb_outer_t tap7_r;
   ftcb_outer_t tap7_nxt;
   ftcb_outer_t tap8_r;
   ftcb_outer_t tap8_nxt;
   logic src_b_r;
   logic src_b_nxt;

   assign dec = ftcb_decode(reg_addr_in);
   assign st_if.hit = dec[SLOT_W];
   assign st_if.slot = dec[SLOT_W-1:0];
   // Writes outside the bank never reach the store
   assign st_if.wr = reg_wr_in && dec[SLOT_W];
   assign st_if.rd = reg_rd_in;
   assign st_if.wdata = reg_wdata_in;

   ftcb_store u_store (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .bus_if(st_if.store)
   );

   assign mode = dual_mode_in ? FTCB_DUAL : FTCB_SINGLE;

   always_comb begin
      rvalid_nxt = reg_rd_in;
      src_b_nxt = src_b_r;
      tap4_nxt = tap4_r;
      tap5_nxt = tap5_r;
      tap6_nxt = tap6_r;
      tap7_nxt = tap7_r;
      tap8_nxt = tap8_r;
      unique case (mode)
         FTCB_DUAL: begin
            src_b_nxt = 1'b1;
            // Reserved bits above each field are stored but never reach the taps
            tap4_nxt = ftcb_center_t'(st_if.image[TAP4_LSB +: CENTER_W]);
            tap5_nxt = ftcb_outer_t'(st_if.image[TAP5_LSB +: OUTER_W]);
            tap6_nxt = ftcb_outer_t'(st_if.image[TAP6_LSB +: OUTER_W]);
            tap7_nxt = ftcb_outer_t'(st_if.image[TAP7_LSB +: OUTER_W]);
            tap8_nxt = ftcb_outer_t'(st_if.image[TAP8_LSB +: OUTER_W]);
         end
         FTCB_SINGLE: begin
            src_b_nxt = 1'b0;
            tap4_nxt = chan_a_tap4_in;
            tap5_nxt = chan_a_tap5_in;
            tap6_nxt = chan_a_tap6_in;
            tap7_nxt = chan_a_tap7_in;
            tap8_nxt = chan_a_tap8_in;
         end
      endcase
   end

   // Reloaded every cycle, so a write reaches the filter two edges later
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rvalid_r <= 1'b0;
         src_b_r <= 1'b0;
         tap4_r <= '0;
         tap5_r <= '0;
         tap6_r <= '0;
         tap7_r <= '0;
         tap8_r <= '0;
      end else begin
         rvalid_r <= rvalid_nxt;
         src_b_r <= src_b_nxt;
         tap4_r <= tap4_nxt;
         tap5_r <= tap5_nxt;
         tap6_r <= tap6_nxt;
         tap7_r <= tap7_nxt;
         tap8_r <= tap8_nxt;
      end
   end

   assign reg_rdata_out = st_if.rdata;
   assign reg_rvalid_out = rvalid_r;
   // Outputs are signed so the datapath multiplies them as two's complement
   assign tap4_coeff_out = tap4_r;
   assign tap5_coeff_out = tap5_r;
   assign tap6_coeff_out = tap6_r;
   assign tap7_coeff_out = tap7_r;
   assign tap8_coeff_out = tap8_r;
   assign tap_src_b_out = src_b_r;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);

   property p_center_low;
      (reg_wr_in && reg_addr_in == TAP4_ADDR && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == TAP4_ADDR))
         |=> tap4_coeff_out[DATA_W-1:0] == $past(reg_wdata_in, 2);
   endproperty
   a_center_low: assert property (p_center_low) else $error("centre tap low byte wrong");

   property p_center_top;
      (st_if.wr && st_if.slot == TAP4_TOP_SLOT && dual_mode_in)
         ##1 (dual_mode_in && !(st_if.wr && st_if.slot == TAP4_TOP_SLOT))
         |=> tap4_coeff_out[CENTER_W-1:CENTER_W-2] == $past(reg_wdata_in[1:0], 2);
   endproperty
   a_center_top: assert property (p_center_top) else $error("centre tap top bits wrong");

   property p_tap5;
      (reg_wr_in && reg_addr_in == TAP5_ADDR && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == TAP5_ADDR))
         |=> tap5_coeff_out[DATA_W-1:0] == $past(reg_wdata_in, 2);
   endproperty
   a_tap5: assert property (p_tap5) else $error("sixth tap wrong");

   property p_tap6;
      (reg_wr_in && reg_addr_in == TAP6_ADDR && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == TAP6_ADDR))
         |=> tap6_coeff_out[DATA_W-1:0] == $past(reg_wdata_in, 2);
   endproperty
   a_tap6: assert property (p_tap6) else $error("seventh tap wrong");

   property p_tap7;
      (reg_wr_in && reg_addr_in == TAP7_ADDR && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == TAP7_ADDR))
         |=> tap7_coeff_out[DATA_W-1:0] == $past(reg_wdata_in, 2);
   endproperty
   a_tap7: assert property (p_tap7) else $error("eighth tap wrong");

   property p_tap8;
      (reg_wr_in && reg_addr_in == TAP8_ADDR && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == TAP8_ADDR))
         |=> tap8_coeff_out[DATA_W-1:0] == $past(reg_wdata_in, 2);
   endproperty
   a_tap8: assert property (p_tap8) else $error("ninth tap wrong");

   property p_tap8_sign;
      (reg_wr_in && reg_addr_in == BANK_LAST_ADDR && reg_wdata_in[3] && dual_mode_in)
         ##1 (dual_mode_in && !(reg_wr_in && reg_addr_in == BANK_LAST_ADDR))
         |=> tap8_coeff_out < 0;
   endproperty
   a_tap8_sign: assert property (p_tap8_sign) else $error("ninth tap not negative");

   property p_msb_read;
      reg_rd_in && reg_addr_in == BANK_LAST_ADDR |=> reg_rvalid_out && !reg_rdata_out[3];
   endproperty
   a_msb_read: assert property (p_msb_read) else $error("ninth tap MSB read back");

   property p_single;
      !dual_mode_in |=> !tap_src_b_out && tap5_coeff_out == $past(chan_a_tap5_in)
         && tap4_coeff_out == $past(chan_a_tap4_in);
   endproperty
   a_single: assert property (p_single) else $error("single mode tap source wrong");

   property p_steady;
      (dual_mode_in && !reg_wr_in) [*2] |=> $stable(tap6_coeff_out) && $stable(tap4_coeff_out);
   endproperty
   a_steady: assert property (p_steady) else $error("taps moved without a write");

   property p_unmapped;
      reg_rd_in && !dec[SLOT_W] |=> reg_rdata_out == READ_NONE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_cov_center;
      reg_wr_in && reg_addr_in == TAP4_ADDR && dual_mode_in ##2 tap4_coeff_out != 0;
   endproperty
   c_cov_center: cover property (p_cov_center);

   property p_cov_single;
      dual_mode_in ##1 !dual_mode_in ##1 !tap_src_b_out;
   endproperty
   c_cov_single: cover property (p_cov_single);

   property p_cov_msb;
      reg_wr_in && reg_addr_in == BANK_LAST_ADDR && reg_wdata_in[3]
         ##[1:20] reg_rd_in && reg_addr_in == BANK_LAST_ADDR;
   endproperty
   c_cov_msb: cover property (p_cov_msb);

endmodule

// ==== dv/ftcb_bank_bench.sv ====
// Self-checking bench for the channel B upper tap coefficient bank.
// Assumes the bank's byte port and one 20 MHz clock; drives every port itself.
`timescale 1ns/1ps
module ftcb_bank_bench;
   import ftcb_pkg::*;
   logic clock_in, nrst_in, reg_wr_in, reg_rd_in, dual_mode_in, snap;
   logic reg_rvalid_out, tap_src_b_out;
   logic [ADDR_W-1:0] reg_addr_in;
   logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, rnd;
   ftcb_center_t chan_a_tap4_in, tap4_coeff_out;
   ftcb_outer_t chan_a_tap5_in, chan_a_tap6_in, chan_a_tap7_in, chan_a_tap8_in;
   ftcb_outer_t tap5_coeff_out, tap6_coeff_out, tap7_coeff_out, tap8_coeff_out;
   logic [DATA_W-1:0] img [NUM_SLOTS];
   logic [DATA_W-1:0] rd_q [$];
   logic [66:0] tap_q [$];
   logic [66:0] e;
   int fails, total_checks, seed;

   ftcb_bank dut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .dual_mode_in(dual_mode_in), .chan_a_tap4_in(chan_a_tap4_in),
      .chan_a_tap5_in(chan_a_tap5_in), .chan_a_tap6_in(chan_a_tap6_in),
      .chan_a_tap7_in(chan_a_tap7_in), .chan_a_tap8_in(chan_a_tap8_in),
      .tap4_coeff_out(tap4_coeff_out), .tap5_coeff_out(tap5_coeff_out),
      .tap6_coeff_out(tap6_coeff_out), .tap7_coeff_out(tap7_coeff_out),
      .tap8_coeff_out(tap8_coeff_out), .tap_src_b_out(tap_src_b_out));

   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end

   task automatic print_verdict();
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp_taps(input string name, input logic [66:0] exp, input logic [66:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One bus cycle; strobes stay up across back-to-back calls
   task automatic bus(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge clock_in);
      reg_wr_in <= w;
      reg_rd_in <= r;
      reg_addr_in <= a;
      reg_wdata_in <= d;
   endtask

   function automatic logic in_bank(input logic [ADDR_W-1:0] a);
      return a >= TAP4_ADDR && a <= BANK_LAST_ADDR;
   endfunction

   task automatic wr_byte(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      if (in_bank(a)) begin
         img[a - TAP4_ADDR] = d;
      end
      bus(1'b1, 1'b0, a, d);
   endtask

   // Ninth tap top byte reads back with its coefficient MSB cleared
   task automatic rd_byte(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] x;
      x = in_bank(a) ? img[a - TAP4_ADDR] : 8'h00;
      if (a == BANK_LAST_ADDR) begin
         x = x & 8'hf7;
      end
      rd_q.push_back(x);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask

   // Reserved bytes and bits never reach the taps
   function automatic logic [66:0] exp_taps();
      if (dual_mode_in) begin
         return {1'b1, img[2][1:0], img[1], img[0], img[4][3:0], img[3], img[6][3:0],
                 img[5], img[8][3:0], img[7], img[10][3:0], img[9]};
      end
      return {1'b0, chan_a_tap4_in, chan_a_tap5_in, chan_a_tap6_in, chan_a_tap7_in,
              chan_a_tap8_in};
   endfunction

   task automatic check_taps();
      bus(1'b0, 1'b0, 15'h0000, 8'h00);
      tap_q.push_back(exp_taps());
      @(posedge clock_in);
      snap <= 1'b1;
      @(posedge clock_in);
      snap <= 1'b0;
   endtask

   task automatic set_mode(input logic m);
      bus(1'b0, 1'b0, 15'h0000, 8'h00);
      dual_mode_in <= m;
      chan_a_tap4_in <= 18'($random(seed));
      chan_a_tap5_in <= 12'($random(seed));
      chan_a_tap6_in <= 12'($random(seed));
      chan_a_tap7_in <= 12'($random(seed));
      chan_a_tap8_in <= 12'($random(seed));
   endtask

   always @(posedge clock_in) begin
      if (reg_rvalid_out === 1'b1) begin
         cmp_byte("rdata", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, reg_rdata_out);
      end
      if (snap === 1'b1) begin
         e = tap_q.pop_front();
         cmp_taps("taps", e, {tap_src_b_out, tap4_coeff_out, tap5_coeff_out, tap6_coeff_out,
                  tap7_coeff_out, tap8_coeff_out});
         cmp_taps("tap8_sign", 67'(e[11]), 67'($signed(tap8_coeff_out) < 0));
      end
   end

   initial begin
      #200000;
      fails++;
      print_verdict();
   end

   initial begin
      seed = 28;
      fails = 0;
      total_checks = 0;
      snap = 1'b0;
      nrst_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 15'h0000;
      reg_wdata_in = 8'h00;
      dual_mode_in = 1'b0;
      chan_a_tap4_in = 18'h00000;
      chan_a_tap5_in = 12'h000;
      chan_a_tap6_in = 12'h000;
      chan_a_tap7_in = 12'h000;
      chan_a_tap8_in = 12'h000;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         img[i] = 8'h00;
      end
      repeat (12) @(posedge clock_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         rd_byte(15'h044f + 15'(i));
      end
      set_mode(1'b0);
      check_taps();
      set_mode(1'b1);
      check_taps();
      // Last round sets every bit, so all five taps go negative
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            rnd = (r == 3) ? 8'hff : 8'($random(seed));
            wr_byte(TAP4_ADDR + 15'(i), rnd);
         end
         wr_byte(15'h044f, 8'($random(seed)));
         wr_byte(15'h045b, 8'($random(seed)));
         check_taps();
         for (int i = 0; i < 13; i++) begin
            rd_byte(15'h044f + 15'(i));
         end
      end
      set_mode(1'b0);
      check_taps();
      set_mode(1'b1);
      check_taps();
      repeat (4) bus(1'b0, 1'b0, 15'h0000, 8'h00);
      cmp_byte("pending_reads", 8'h00, 8'(rd_q.size()));
      print_verdict();
   end
endmodule
